/* File: design/lanwl_pkg.sv */
// Package of constants and carrier types for the initial word loader.
package lanwl_pkg;

  // ************************************************************
  // Word bit positions
  // ************************************************************
  localparam int unsigned PIN_ZERO_DATA_POS = 0;
  localparam int unsigned PIN_ONE_DATA_POS = 1;
  localparam int unsigned COLD_WAKE_ADV_POS = 2;
  localparam int unsigned GIGA_OFF_LOW_PWR_POS = 3;
  localparam int unsigned PIN_ZERO_DIR_POS = 8;
  localparam int unsigned PIN_ONE_DIR_POS = 9;
  localparam int unsigned PREFETCH_POS = 9;
  localparam int unsigned NARROW_BASE_POS = 10;

  // ************************************************************
  // Values after reset, before any word has been loaded
  // ************************************************************
  localparam logic RST_GIGA_OFF_LOW_PWR = 1'h1;
  localparam logic RST_COLD_WAKE_ADV = 1'h1;
  localparam logic RST_PIN_DATA = 1'h0;
  localparam logic RST_PIN_DIR = 1'h0;
  localparam logic RST_NARROW_BASE = 1'h1;
  localparam logic RST_PREFETCH = 1'h0;

  // Base address register type field encodings.
  localparam logic [1:0] BAR_TYPE_32 = 2'h0;
  localparam logic [1:0] BAR_TYPE_64 = 2'h2;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic giga_off_low_pwr;
    logic cold_wake_advertise_enable;
    logic pin_one_data_bit;
    logic pin_zero_data_bit;
    logic pin_one_direction_bit;
    logic pin_zero_direction_bit;
    logic narrow_base_layout_sel;
    logic prefetch_attribute_sel;
  } lanwl_cfg_t;

  typedef struct packed {
    lanwl_cfg_t cfg;
    logic pin_loaded;
    logic func_loaded;
  } lanwl_state_t;

endpackage

/* File: design/lanwl_loader.sv */
// Initial word loader for pin-control and functions-control configuration words.
`timescale 1ns/1ns

module lanwl_loader
  import lanwl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_word_valid_i,
  input wire logic [15:0] pin_word_i,
  input wire logic func_word_valid_i,
  input wire logic [15:0] func_word_i,
  input wire logic fully_active_power_state_i,
  input wire logic aux_power_present_i,
  output logic giga_block_o,
  output logic pm_cold_wake_cap_o,
  output logic cold_wake_advertise_ctl_o,
  output logic pin_one_data_bit_o,
  output logic pin_zero_data_bit_o,
  output logic pin_one_direction_bit_o,
  output logic pin_zero_direction_bit_o,
  output logic general_soft_pin1_o,
  output logic general_soft_pin1_oe_o,
  output logic general_soft_pin0_o,
  output logic general_soft_pin0_oe_o,
  output logic narrow_base_layout_sel_o,
  output logic prefetch_attribute_sel_o,
  output logic [1:0] bar_type_o,
  output logic pin_loaded_o,
  output logic func_loaded_o
);

  // ************************************************************
  // Local constants
  // ************************************************************
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PIN_COUNT = 2;

  // Held from reset until the store hands a word over, so a part with an empty store
  // still blocks gigabit in low power and shows the legacy 32-bit layout.
  localparam lanwl_cfg_t CFG_AT_RESET = '{
    giga_off_low_pwr: RST_GIGA_OFF_LOW_PWR,
    cold_wake_advertise_enable: RST_COLD_WAKE_ADV,
    pin_one_data_bit: RST_PIN_DATA,
    pin_zero_data_bit: RST_PIN_DATA,
    pin_one_direction_bit: RST_PIN_DIR,
    pin_zero_direction_bit: RST_PIN_DIR,
    narrow_base_layout_sel: RST_NARROW_BASE,
    prefetch_attribute_sel: RST_PREFETCH
  };

  localparam lanwl_state_t STATE_AT_RESET = '{
    cfg: CFG_AT_RESET,
    pin_loaded: 1'h0,
    func_loaded: 1'h0
  };

  // ************************************************************
  // Word decoding
  // ************************************************************
  // Copies the used pin-control fields over an existing configuration.
  function automatic lanwl_cfg_t take_pin_word(
    input lanwl_cfg_t cur,
    input logic [WORD_W-1:0] word
  );
    lanwl_cfg_t upd;
    upd = cur;
    upd.giga_off_low_pwr = word[GIGA_OFF_LOW_PWR_POS];
    upd.cold_wake_advertise_enable = word[COLD_WAKE_ADV_POS];
    upd.pin_one_data_bit = word[PIN_ONE_DATA_POS];
    upd.pin_zero_data_bit = word[PIN_ZERO_DATA_POS];
    upd.pin_one_direction_bit = word[PIN_ONE_DIR_POS];
    upd.pin_zero_direction_bit = word[PIN_ZERO_DIR_POS];
    return upd;
  endfunction

  // Only the layout and prefetch bits are picked out; the reserved bits have no path onward.
  function automatic lanwl_cfg_t take_func_word(
    input lanwl_cfg_t cur,
    input logic [WORD_W-1:0] word
  );
    lanwl_cfg_t upd;
    upd = cur;
    upd.narrow_base_layout_sel = word[NARROW_BASE_POS];
    upd.prefetch_attribute_sel = word[PREFETCH_POS];
    return upd;
  endfunction

  // In the fully active state the link is never held back, whatever was loaded.
  function automatic logic blocks_gigabit(
    input lanwl_cfg_t cfg,
    input logic fully_active
  );
    return cfg.giga_off_low_pwr & ~fully_active;
  endfunction

  // Without auxiliary power no wake from cold can be promised, whatever the store says.
  function automatic logic reports_cold_wake(
    input lanwl_cfg_t cfg,
    input logic aux_present
  );
    return cfg.cold_wake_advertise_enable & aux_present;
  endfunction

  // The layout bit is used as loaded, even when it is paired badly with the prefetch bit.
  function automatic logic [1:0] bar_type_of(
    input lanwl_cfg_t cfg
  );
    logic [1:0] code;
    if (cfg.narrow_base_layout_sel) begin
      code = BAR_TYPE_32;
    end else begin
      code = BAR_TYPE_64;
    end
    return code;
  endfunction

  // Index one is general pin one and index zero is general pin zero.
  function automatic logic [PIN_COUNT-1:0] pin_data_of(
    input lanwl_cfg_t cfg
  );
    return {cfg.pin_one_data_bit, cfg.pin_zero_data_bit};
  endfunction

  function automatic logic [PIN_COUNT-1:0] pin_dir_of(
    input lanwl_cfg_t cfg
  );
    return {cfg.pin_one_direction_bit, cfg.pin_zero_direction_bit};
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  lanwl_state_t state_r;
  lanwl_state_t state_nxt;

  // Both words may arrive in one cycle; they touch separate fields, so neither hides the other.
  always_comb begin
    state_nxt = state_r;
    if (pin_word_valid_i) begin
      state_nxt.cfg = take_pin_word(state_nxt.cfg, pin_word_i);
      state_nxt.pin_loaded = 1'h1;
    end
    if (func_word_valid_i) begin
      state_nxt.cfg = take_func_word(state_nxt.cfg, func_word_i);
      state_nxt.func_loaded = 1'h1;
    end
  end

  // The reset is asynchronous so the defaults stand even before the clock runs.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= STATE_AT_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // General pins
  // ************************************************************
  lanwl_cfg_t cfg_w;
  logic [PIN_COUNT-1:0] pin_data_w;
  logic [PIN_COUNT-1:0] pin_dir_w;
  logic [PIN_COUNT-1:0] pin_level_w;
  logic [PIN_COUNT-1:0] pin_enable_w;

  assign cfg_w = state_r.cfg;
  assign pin_data_w = pin_data_of(cfg_w);
  assign pin_dir_w = pin_dir_of(cfg_w);

  // The level is presented even while a pin is an input; the pad ignores it until enabled.
  for (genvar pin_idx = 0; pin_idx < PIN_COUNT; pin_idx++) begin : gen_pin
    assign pin_level_w[pin_idx] = pin_data_w[pin_idx];
    assign pin_enable_w[pin_idx] = pin_dir_w[pin_idx];
  end

  assign pin_one_data_bit_o = pin_data_w[1];
  assign pin_zero_data_bit_o = pin_data_w[0];
  assign pin_one_direction_bit_o = pin_dir_w[1];
  assign pin_zero_direction_bit_o = pin_dir_w[0];
  assign general_soft_pin1_o = pin_level_w[1];
  assign general_soft_pin1_oe_o = pin_enable_w[1];
  assign general_soft_pin0_o = pin_level_w[0];
  assign general_soft_pin0_oe_o = pin_enable_w[0];

  // ************************************************************
  // Power management outputs
  // ************************************************************
  // Power state and aux power act at once, so a state change is never seen a cycle late.
  assign giga_block_o = blocks_gigabit(cfg_w, fully_active_power_state_i);
  assign pm_cold_wake_cap_o = reports_cold_wake(cfg_w, aux_power_present_i);
  assign cold_wake_advertise_ctl_o = cfg_w.cold_wake_advertise_enable;

  // ************************************************************
  // Base address outputs
  // ************************************************************
  assign narrow_base_layout_sel_o = cfg_w.narrow_base_layout_sel;
  assign prefetch_attribute_sel_o = cfg_w.prefetch_attribute_sel;
  assign bar_type_o = bar_type_of(cfg_w);

  // ************************************************************
  // Load tracking
  // ************************************************************
  // The flags stay set until reset, so a later reload of the same word leaves them alone.
  assign pin_loaded_o = state_r.pin_loaded;
  assign func_loaded_o = state_r.func_loaded;

endmodule

/* File: test/lanwl_store.sv */
// Word store model that hands one configuration word to the loader.
`timescale 1ns/1ns
module lanwl_store (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [15:0] data_i,
  output logic valid_o,
  output logic [15:0] word_o
);
  initial {valid_o, word_o} = '0;
  // Idle lines toggle so that a stale word is never mistaken for a fresh one.
  // The request is sampled at the edge itself, so a bench that drops it 1 ns later never races.
  always @(posedge clk_i) begin
    valid_o <= #1 req_i;
    word_o <= #1 (req_i ? data_i : ~word_o);
  end
endmodule

/* File: test/lanwl_loader_chk.sv */
// Checker of the loader port relations.
`timescale 1ns/1ns
module lanwl_loader_chk
  import lanwl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_word_valid_i,
  input wire logic func_word_valid_i,
  input wire logic [15:0] pin_word_i,
  input wire logic [15:0] func_word_i,
  input wire logic fully_active_power_state_i,
  input wire logic aux_power_present_i,
  input wire logic giga_block_o,
  input wire logic pm_cold_wake_cap_o,
  input wire logic cold_wake_advertise_ctl_o,
  input wire logic pin_one_data_bit_o,
  input wire logic pin_zero_data_bit_o,
  input wire logic pin_one_direction_bit_o,
  input wire logic pin_zero_direction_bit_o,
  input wire logic general_soft_pin1_o,
  input wire logic general_soft_pin1_oe_o,
  input wire logic general_soft_pin0_o,
  input wire logic general_soft_pin0_oe_o,
  input wire logic narrow_base_layout_sel_o,
  input wire logic prefetch_attribute_sel_o,
  input wire logic [1:0] bar_type_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_GIGA_D0: assert property (fully_active_power_state_i |-> !giga_block_o)
    else $error("gigabit blocked in active state");
  AST_GIGA_LOAD: assert property (pin_word_valid_i ##1 !fully_active_power_state_i
    |-> giga_block_o == $past(pin_word_i[3])) else $error("gigabit block wrong");
  AST_WAKE: assert property (pm_cold_wake_cap_o ==
    (cold_wake_advertise_ctl_o && aux_power_present_i)) else $error("wake report wrong");
  AST_ADV: assert property (pin_word_valid_i |=>
    cold_wake_advertise_ctl_o == $past(pin_word_i[2])) else $error("advertise copy wrong");
  AST_DATA: assert property (pin_word_valid_i |=>
    {pin_one_data_bit_o, pin_zero_data_bit_o} == $past(pin_word_i[1:0])) else $error("data");
  AST_DRIVE: assert property ({general_soft_pin1_oe_o, general_soft_pin0_oe_o,
    general_soft_pin1_o, general_soft_pin0_o} == {pin_one_direction_bit_o,
    pin_zero_direction_bit_o, pin_one_data_bit_o, pin_zero_data_bit_o}) else $error("pin");
  AST_BAR: assert property (func_word_valid_i |=> narrow_base_layout_sel_o ==
    $past(func_word_i[10]) && bar_type_o == (narrow_base_layout_sel_o ? BAR_TYPE_32 :
    BAR_TYPE_64)) else $error("base layout wrong");
  AST_PREF: assert property (func_word_valid_i |=>
    prefetch_attribute_sel_o == $past(func_word_i[9])) else $error("prefetch wrong");
  AST_FUNC_HOLD: assert property (!func_word_valid_i |=>
    $stable(narrow_base_layout_sel_o) && $stable(prefetch_attribute_sel_o))
    else $error("base bits moved without a load");
  AST_PIN_HOLD: assert property (!pin_word_valid_i |=>
    $stable(pin_one_data_bit_o) && $stable(pin_zero_data_bit_o))
    else $error("pin data moved without a load");
  cover property (func_word_valid_i ##1 !narrow_base_layout_sel_o);
  cover property (pm_cold_wake_cap_o);
  cover property (general_soft_pin1_oe_o && general_soft_pin1_o);
  cover property (pin_word_valid_i && !func_word_valid_i);
endmodule
bind lanwl_loader lanwl_loader_chk lanwl_loader_chk_inst (.*);

/* File: test/test_lanwl_loader.sv */
// Self-checking bench of the loader fed by two word store models.
`timescale 1ns/1ns
module test_lanwl_loader
  import lanwl_pkg::*;
;
  logic clk_i, rst_b_i, pin_word_valid_i, func_word_valid_i, pin_req, func_req;
  logic fully_active_power_state_i, aux_power_present_i, giga_block_o, pm_cold_wake_cap_o;
  logic cold_wake_advertise_ctl_o, pin_one_data_bit_o, pin_zero_data_bit_o, pin_loaded_o;
  logic pin_one_direction_bit_o, pin_zero_direction_bit_o, general_soft_pin1_o, func_loaded_o;
  logic general_soft_pin1_oe_o, general_soft_pin0_o, general_soft_pin0_oe_o;
  logic narrow_base_layout_sel_o, prefetch_attribute_sel_o;
  logic [1:0] bar_type_o;
  logic [15:0] pin_word_i, func_word_i, pw, fw, r, pe, fe;
  logic [1:0] lde;
  int mismatches = 0, check_count = 0;
  lanwl_loader lanwl_loader_inst (.*);
  lanwl_store pin_store_inst (.clk_i(clk_i), .req_i(pin_req), .data_i(pw),
    .valid_o(pin_word_valid_i), .word_o(pin_word_i));
  lanwl_store func_store_inst (.clk_i(clk_i), .req_i(func_req), .data_i(fw),
    .valid_o(func_word_valid_i), .word_o(func_word_i));
  function automatic logic [16:0] exp_of(logic [15:0] p, f, logic [1:0] ld, logic fa, ax);
    return {p[3] & ~fa, p[2] & ax, p[2], p[1:0], p[9:8], p[1], p[9], p[0], p[8], f[10], f[9],
      f[10] ? BAR_TYPE_32 : BAR_TYPE_64, ld};
  endfunction
  task automatic check(logic [16:0] got, want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic see(logic [15:0] p, f, logic [1:0] ld);
    check({giga_block_o, pm_cold_wake_cap_o, cold_wake_advertise_ctl_o, pin_one_data_bit_o,
      pin_zero_data_bit_o, pin_one_direction_bit_o, pin_zero_direction_bit_o,
      general_soft_pin1_o, general_soft_pin1_oe_o, general_soft_pin0_o, general_soft_pin0_oe_o,
      narrow_base_layout_sel_o, prefetch_attribute_sel_o, bar_type_o, pin_loaded_o,
      func_loaded_o}, exp_of(p, f, ld, fully_active_power_state_i, aux_power_present_i));
  endtask
  task automatic load(logic [15:0] p, f, logic [1:0] w);
    {pw, fw, pin_req, func_req} = {p, f, w};
    {fully_active_power_state_i, aux_power_present_i} = 2'($urandom);
    @(posedge clk_i) #1 {pin_req, func_req} = 2'h0;
    if (w[1]) pe = p;
    if (w[0]) fe = f;
    lde = lde | w;
    @(posedge clk_i) #1 see(pe, fe, lde);
  endtask
  task automatic do_reset();
    rst_b_i = 1'h0;
    {pe, fe, lde} = {16'h000c, 16'h0400, 2'h0};
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'h1;
    see(pe, fe, lde);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #20000 mismatches++;
    close_out();
  end
  initial begin
    {pin_req, func_req, pw, fw, fully_active_power_state_i, aux_power_present_i} = '0;
    void'($urandom(68078));
    do_reset();
    load(16'h030b, 16'h0200, 2'h3);
    load(16'hf4f0, 16'hfdff, 2'h3);
    load(16'h0000, 16'h0000, 2'h2);
    load(16'hfcf3, 16'h0200, 2'h1);
    repeat (40) begin
      r = 16'($urandom);
      if (r[9]) r[10] = 1'h0;
      load(16'($urandom), r, 2'($urandom));
    end
    do_reset();
    load(16'h030b, 16'h0400, 2'h3);
    close_out();
  end
endmodule
